// >>> logic/word_cpu_pkg.sv
// Package: shared constants and types for the word processor decode/execute block.
// Assumes a single 25 MHz clock domain and an AHB-Lite register bus.
`default_nettype none
package word_cpu_pkg;
  // Word geometry.
  localparam int W  = 30;  // Single word width.
  localparam int HW = 15;  // Half word width.
  localparam int AW = 17;  // Indexed address width.
  // Register byte offsets.
  localparam logic [7:0] OFF_INSTR = 8'h00;  // Instruction word; a write executes it.
  localparam logic [7:0] OFF_ACC   = 8'h04;  // Accumulator.
  localparam logic [7:0] OFF_QREG  = 8'h08;  // Q register.
  localparam logic [7:0] OFF_OPND  = 8'h0c;  // Storage word at Y.
  localparam logic [7:0] OFF_OPND2 = 8'h10;  // Storage word at Y+1.
  localparam logic [7:0] OFF_RELOC = 8'h14;  // Relocation base.
  localparam logic [7:0] OFF_LIMIT = 8'h18;  // Limit base.
  localparam logic [7:0] OFF_CTRL  = 8'h1c;  // Bit 0 selects the limit base.
  localparam logic [7:0] OFF_STAT  = 8'h20;  // Flags.
  localparam logic [7:0] OFF_EFF   = 8'h24;  // Last effective operand.
  localparam logic [7:0] OFF_PC    = 8'h28;  // Relative program location.
  localparam logic [7:0] OFF_RET   = 8'h2c;  // Saved return location.
  localparam logic [7:0] OFF_IDX   = 8'h40;  // Index register b at OFF_IDX + 4*b.
  // Reset values.
  localparam logic [W-1:0] RST_WORD = 30'h0;
  // Status bit positions.
  localparam int ST_SKIP = 0;
  localparam int ST_FPOK = 1;
  localparam int ST_BUSY = 2;
  localparam int ST_EXT  = 3;
  // Function codes.
  localparam logic [5:0] F_LDA = 6'h08, F_LDQ = 6'h09, F_STA = 6'h0a, F_STQ = 6'h0b;
  localparam logic [5:0] F_ADD = 6'h0c, F_SUB = 6'h0d, F_DAD = 6'h0e, F_BCD = 6'h0f;
  localparam logic [5:0] F_AND = 6'h10, F_SST = 6'h11, F_SCL = 6'h12, F_SCP = 6'h13;
  localparam logic [5:0] F_SSU = 6'h14, F_SRZ = 6'h15, F_SRS = 6'h16, F_SLR = 6'h17;
  localparam logic [5:0] F_CMP = 6'h18, F_CMA = 6'h19, F_MCM = 6'h1a, F_JMP = 6'h1b;
  localparam logic [5:0] F_RPT = 6'h1c, F_PAK = 6'h1d, F_UNP = 6'h1e, F_IO  = 6'h1f;
  localparam logic [5:0] F_EXT = 6'h3f;
  // Extended function codes.
  localparam logic [5:0] G_SCALE = 6'h18;
  localparam logic [5:0] G_FCHK  = 6'h01;
  // Characters per word.
  localparam logic [2:0] CHARS = 3'd5;
  // Normal instruction word layout.
  typedef struct packed {
    logic [5:0]    op;    // Function code.
    logic [2:0]    mod;   // Skip, register, repeat or jump selector.
    logic [2:0]    part;  // Operand portion and destination.
    logic [2:0]    idx;   // Index register select.
    logic [HW-1:0] y;     // Operand value.
  } instr_t;
  // Storage write request.
  typedef struct packed {
    logic          we;
    logic [AW-1:0] addr;
    logic [W-1:0]  data;
  } mem_req_t;
  // I/O channel start request.
  typedef struct packed {
    logic       start;
    logic [3:0] chan;
    logic [1:0] mode;
  } io_req_t;
endpackage : word_cpu_pkg
`default_nettype wire

// >>> logic/word_cpu_decode_execute.sv
// Decode and execute unit for a 30-bit ones-complement word processor.
// Assumes one AHB-Lite master; storage operands are supplied through registers.
// Operation
// - Normal word: function, modifier, portion, index, value.
// - Six-bit function code picks the operation.
// - Modifier means skip, register, repeat or jump.
// - Portion code picks whole, upper or lower.
// - Nonzero index adds index register to value.
// - Location is indexed address plus base.
// - Read, store and replace class data moves.
// - Function all ones selects extended code.
// - I/O: four-bit channel, two-bit operand mode.
// - Execution continues while I/O transfer runs.
// - Transfers leave the source unchanged.
// - Pack and unpack five characters, successive addresses.
// - Right shift drops bits, zero or sign fill.
// - Left shift rotates top bit to bottom.
// - Count from low six bits; scale normalises.
// - Compare skips; alpha or arithmetic top bit.
// - Masked compare uses selected bits only.
// - Repeat, skip, jump; jump saves return.
// - Single word sign bit 29, ones complement.
// - Double precision sixty-bit ones-complement arithmetic.
// - Decimal add on ten characters, zones kept.
// - Floating operands checked for accepted range.
// - Logical product, selective set, clear, complement.
// - Selective substitute copies selected operand bits.
`default_nettype none
module word_cpu_decode_execute #(
  parameter int RPT_W = 6  // Width of the repeat counter.
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  output word_cpu_pkg::mem_req_t     mem,
  output word_cpu_pkg::io_req_t      io
);
  // Repeat counts must fit the six-bit operand field.
  if (RPT_W < 1 || RPT_W > 6) begin : g_chk
    $error("RPT_W out of range");
  end

  // Bus data-phase capture.
  logic                    dp_wr;    // Write data phase pending.
  logic [7:0]              dp_addr;  // Captured byte offset.
  // Architectural state.
  word_cpu_pkg::instr_t    ir;       // Current instruction.
  logic                    go;       // Execute ir this cycle.
  logic [29:0]             acc, qr, opnd, opnd2, rel, lim, eff_r;
  logic                    use_lim;  // Limit base selected.
  logic [16:0]             pc, ret;
  logic [16:0]             idx [1:7];
  logic [RPT_W-1:0]        rpt_left; // Remaining repeat executions.
  logic [2:0]              chr;      // Character step within a word.
  logic                    skip, fp_ok;

  // Zero-wait slave, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase decode.
  wire        ap_ok   = hsel && htrans[1] && hready;
  wire        wr_go   = dp_wr && dp_addr == word_cpu_pkg::OFF_INSTR && !go;

  // Field decode.
  wire [5:0]  op      = ir.op;
  wire        is_ext  = op == word_cpu_pkg::F_EXT;
  wire [5:0]  gcode   = {ir.mod, ir.part};
  wire        is_io   = op == word_cpu_pkg::F_IO;
  wire [3:0]  io_ch   = ir[23:20];
  wire [1:0]  io_md   = ir[19:18];
  wire [16:0] bval    = (ir.idx == 3'd0) ? 17'h0 : idx[ir.idx];
  wire [16:0] eff     = {2'b00, ir.y} + bval;
  wire [16:0] base    = use_lim ? lim[16:0] : rel[16:0];
  wire [16:0] phys    = eff + base + {14'h0, chr};
  wire [5:0]  cnt     = eff[5:0];
  wire        dest_st = ir.part[2];

  // Operand portion selection.
  wire [29:0] ysel    = (ir.part[1:0] == 2'd0) ? {13'h0, eff} :
                        (ir.part[1:0] == 2'd1) ? {15'h0, opnd[29:15]} :
                        (ir.part[1:0] == 2'd2) ? {15'h0, opnd[14:0]} : opnd;

  // Adds two words and folds the carry back into bit 0.
  function automatic logic [29:0] oc30(input logic [29:0] a, input logic [29:0] b);
    logic [30:0] s;
    s    = {1'b0, a} + {1'b0, b};
    oc30 = s[29:0] + {29'h0, s[30]};
  endfunction : oc30

  // Sixty-bit form of the same add.
  function automatic logic [59:0] oc60(input logic [59:0] a, input logic [59:0] b);
    logic [60:0] s;
    s    = {1'b0, a} + {1'b0, b};
    oc60 = s[59:0] + {59'h0, s[60]};
  endfunction : oc60

  // Adds ten zoned digits; zone bits come from the first operand.
  function automatic logic [59:0] bcd60(input logic [59:0] a, input logic [59:0] b);
    logic [4:0] d;
    logic       c;
    bcd60 = a;
    c     = 1'b0;
    for (int i = 0; i < 10; i++) begin
      d = {1'b0, a[6*i +: 4]} + {1'b0, b[6*i +: 4]} + {4'h0, c};
      c = d > 5'd9;
      if (c) begin
        d = d - 5'd10;
      end
      bcd60[6*i +: 4] = d[3:0];
    end
  endfunction : bcd60

  // Counts left shifts until bit 28 differs from the sign.
  function automatic logic [5:0] norm_cnt(input logic [29:0] a);
    logic done;
    norm_cnt = 6'd0;
    done     = 1'b0;
    for (int i = 28; i >= 0; i--) begin
      if (!done && a[i] == a[29]) begin
        norm_cnt = norm_cnt + 6'd1;
      end else begin
        done = 1'b1;
      end
    end
  endfunction : norm_cnt

  // Shift and compare helpers.
  // Counts of 60 and up wrap twice, so the rotate never sees more than 29.
  wire [5:0]  rot     = (cnt >= 6'd60) ? cnt - 6'd60 : (cnt >= 6'd30) ? cnt - 6'd30 : cnt;
  wire [59:0] rot2    = {acc, acc} << rot;
  wire [29:0] shr_z   = acc >> cnt;
  wire [29:0] shr_s   = 30'($signed(acc) >>> cnt);
  wire [5:0]  ncnt    = norm_cnt(acc);
  wire        gt_ar   = {~acc[29], acc[28:0]} > {~ysel[29], ysel[28:0]};
  wire        gt_al   = acc > ysel;
  wire        eq_m    = (acc & qr) == (ysel & qr);
  wire [59:0] dsum    = oc60({acc, qr}, {opnd, opnd2});
  wire [59:0] bsum    = bcd60({acc, qr}, {opnd, opnd2});
  wire [10:0] fchar   = acc[29] ? ~acc[28:18] : acc[28:18];
  wire        fnorm   = acc[17] != acc[29];

  // Jump condition chosen by the modifier.
  logic jcond;
  always_comb begin
    case (ir.mod)
      3'd0:    jcond = 1'b1;
      3'd1:    jcond = acc == 30'h0;
      3'd2:    jcond = acc != 30'h0;
      3'd3:    jcond = !acc[29];
      3'd4:    jcond = acc[29];
      default: jcond = 1'b0;
    endcase
  end

  // Execution results for one instruction.
  logic [29:0] next_acc, next_qr, next_wd;
  logic [16:0] next_pc, next_ret;
  logic        next_we, next_skip, next_fp, next_io;
  logic [2:0]  next_chr;
  logic [29:0] res;
  always_comb begin
    next_acc  = acc;
    next_qr   = qr;
    next_pc   = pc + 17'd1;
    next_ret  = ret;
    next_we   = 1'b0;
    next_wd   = acc;
    next_skip = 1'b0;
    next_fp   = fp_ok;
    next_io   = 1'b0;
    next_chr  = chr;
    res       = acc;
    case (op)
      word_cpu_pkg::F_LDA: next_acc = ysel;
      word_cpu_pkg::F_LDQ: next_qr  = ysel;
      word_cpu_pkg::F_STA, word_cpu_pkg::F_STQ: begin
        res = (op == word_cpu_pkg::F_STA) ? acc : qr;
        if (dest_st && op == word_cpu_pkg::F_STA) begin
          next_qr = res;
        end else begin
          next_we = 1'b1;
          next_wd = (ir.part[1:0] == 2'd1) ? {res[14:0], opnd[14:0]} :
                    (ir.part[1:0] == 2'd2) ? {opnd[29:15], res[14:0]} : res;
        end
      end
      word_cpu_pkg::F_ADD: res = oc30(acc, ysel);
      word_cpu_pkg::F_SUB: res = oc30(acc, ~ysel);
      word_cpu_pkg::F_AND: res = acc & ysel;
      word_cpu_pkg::F_SST: res = acc | ysel;
      word_cpu_pkg::F_SCL: res = acc & ~ysel;
      word_cpu_pkg::F_SCP: res = acc ^ ysel;
      word_cpu_pkg::F_SSU: res = (acc & ~qr) | (ysel & qr);
      word_cpu_pkg::F_DAD: {next_acc, next_qr} = dsum;
      word_cpu_pkg::F_BCD: {next_acc, next_qr} = bsum;
      word_cpu_pkg::F_SRZ: next_acc = shr_z;
      word_cpu_pkg::F_SRS: next_acc = shr_s;
      word_cpu_pkg::F_SLR: next_acc = rot2[59:30];
      word_cpu_pkg::F_CMP: next_skip = ir.mod[0] ? gt_ar : !gt_ar;
      word_cpu_pkg::F_CMA: next_skip = ir.mod[0] ? gt_al : !gt_al;
      word_cpu_pkg::F_MCM: next_skip = ir.mod[0] ? eq_m : !eq_m;
      word_cpu_pkg::F_JMP: begin
        if (jcond) begin
          next_pc  = eff;
          next_ret = pc + 17'd1;
        end
      end
      word_cpu_pkg::F_PAK: begin
        next_acc = {acc[23:0], opnd[5:0]};
        next_chr = (chr == word_cpu_pkg::CHARS - 3'd1) ? 3'd0 : chr + 3'd1;
      end
      word_cpu_pkg::F_UNP: begin
        next_we  = 1'b1;
        next_wd  = {24'h0, acc[29:24]};
        next_acc = {acc[23:0], acc[29:24]};
        next_chr = (chr == word_cpu_pkg::CHARS - 3'd1) ? 3'd0 : chr + 3'd1;
      end
      word_cpu_pkg::F_IO: next_io = 1'b1;
      word_cpu_pkg::F_EXT: begin
        case (gcode)
          word_cpu_pkg::G_SCALE: begin
            next_acc = acc << ncnt;
            next_qr  = {24'h0, ncnt};
          end
          word_cpu_pkg::G_FCHK: next_fp = fnorm && fchar != 11'h0;
          default: ;
        endcase
      end
      default: ;
    endcase
    // Replace class writes to storage or the accumulator.
    if (op >= word_cpu_pkg::F_ADD && op <= word_cpu_pkg::F_SSU &&
        op != word_cpu_pkg::F_DAD && op != word_cpu_pkg::F_BCD) begin
      if (dest_st) begin
        next_we = 1'b1;
        next_wd = res;
      end else begin
        next_acc = res;
      end
    end
    if (next_skip) begin
      next_pc = pc + 17'd2;
    end
  end

  // Repeat control: re-execute until the count runs out.
  wire is_rpt    = op == word_cpu_pkg::F_RPT;
  wire rep_again = go && !is_rpt && rpt_left > RPT_W'(1);

  // Captures the address phase for the following data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h0;
    end else begin
      dp_wr   <= ap_ok && hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  // Read data is registered in the address phase.
  wire [29:0] stat = {26'h0, is_ext, go, fp_ok, skip};
  wire [7:0]  ra   = haddr[7:0];
  wire [29:0] rd_w =
    (ra == word_cpu_pkg::OFF_INSTR) ? ir :
    (ra == word_cpu_pkg::OFF_ACC)   ? acc :
    (ra == word_cpu_pkg::OFF_QREG)  ? qr :
    (ra == word_cpu_pkg::OFF_OPND)  ? opnd :
    (ra == word_cpu_pkg::OFF_OPND2) ? opnd2 :
    (ra == word_cpu_pkg::OFF_RELOC) ? rel :
    (ra == word_cpu_pkg::OFF_LIMIT) ? lim :
    (ra == word_cpu_pkg::OFF_CTRL)  ? {29'h0, use_lim} :
    (ra == word_cpu_pkg::OFF_STAT)  ? stat :
    (ra == word_cpu_pkg::OFF_EFF)   ? eff_r :
    (ra == word_cpu_pkg::OFF_PC)    ? {13'h0, pc} :
    (ra == word_cpu_pkg::OFF_RET)   ? {13'h0, ret} :
    (ra[7:5] == 3'd2 && ra[4:2] != 3'd0 && ra[1:0] == 2'd0) ?
      {13'h0, idx[ra[4:2]]} : 30'h0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ap_ok && !hwrite) begin
      hrdata <= {2'b00, rd_w};
    end
  end

  // Index registers, one per entry.
  for (genvar b = 1; b <= 7; b++) begin : g_idx
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        idx[b] <= 17'h0;
      end else if (dp_wr && dp_addr == word_cpu_pkg::OFF_IDX + 8'(4 * b)) begin
        idx[b] <= hwdata[16:0];
      end
    end
  end

  // Software registers; a bus write wins over a result in the same cycle.
  wire w_acc = dp_wr && dp_addr == word_cpu_pkg::OFF_ACC;
  wire w_q   = dp_wr && dp_addr == word_cpu_pkg::OFF_QREG;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ir      <= word_cpu_pkg::RST_WORD;
      opnd    <= word_cpu_pkg::RST_WORD;
      opnd2   <= word_cpu_pkg::RST_WORD;
      rel     <= word_cpu_pkg::RST_WORD;
      lim     <= word_cpu_pkg::RST_WORD;
      use_lim <= 1'b0;
    end else begin
      if (wr_go) ir <= hwdata[29:0];
      if (dp_wr && dp_addr == word_cpu_pkg::OFF_OPND) opnd <= hwdata[29:0];
      if (dp_wr && dp_addr == word_cpu_pkg::OFF_OPND2) opnd2 <= hwdata[29:0];
      if (dp_wr && dp_addr == word_cpu_pkg::OFF_RELOC) rel <= hwdata[29:0];
      if (dp_wr && dp_addr == word_cpu_pkg::OFF_LIMIT) lim <= hwdata[29:0];
      if (dp_wr && dp_addr == word_cpu_pkg::OFF_CTRL) use_lim <= hwdata[0];
    end
  end

  // Executes the instruction held in ir.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go       <= 1'b0;
      acc      <= 30'h0;
      qr       <= 30'h0;
      pc       <= 17'h0;
      ret      <= 17'h0;
      eff_r    <= 30'h0;
      rpt_left <= '0;
      chr      <= 3'd0;
      skip     <= 1'b0;
      fp_ok    <= 1'b0;
      mem      <= '0;
      io       <= '0;
    end else begin
      go     <= wr_go || rep_again;
      mem.we <= go && next_we;
      io.start <= go && next_io;
      if (go) begin
        acc <= w_acc ? hwdata[29:0] : next_acc;
        qr  <= w_q ? hwdata[29:0] : next_qr;
        pc       <= next_pc;
        ret      <= next_ret;
        skip     <= next_skip;
        fp_ok    <= next_fp;
        eff_r    <= {13'h0, eff};
        chr      <= next_chr;
        mem.addr <= phys;
        mem.data <= next_wd;
        if (is_io) begin
          io.chan <= io_ch;
          io.mode <= io_md;
        end
        rpt_left <= is_rpt ? cnt[RPT_W-1:0] :
                    (rpt_left != '0) ? rpt_left - RPT_W'(1) : rpt_left;
      end else begin
        if (w_acc) acc <= hwdata[29:0];
        if (w_q) qr <= hwdata[29:0];
      end
    end
  end

  // Checks.
  sequence s_io_exec;
    go && is_io && !w_acc;
  endsequence
  property p_io_start;
    @(posedge hclk) disable iff (!hresetn)
    s_io_exec |=> io.start && io.chan == $past(io_ch) && io.mode == $past(io_md);
  endproperty
  a_io_start: assert property (p_io_start) else $error("io start wrong");
  // An instruction written right behind a channel start is taken at once.
  sequence s_io_next;
    dp_wr && dp_addr == word_cpu_pkg::OFF_INSTR && !go;
  endsequence
  property p_io_free;
    @(posedge hclk) disable iff (!hresetn)
    s_io_exec ##1 s_io_next |=> go && ir == $past(hwdata[29:0]);
  endproperty
  a_io_free: assert property (p_io_free) else $error("io stalled");
  property p_store_addr;
    @(posedge hclk) disable iff (!hresetn)
    go && op == word_cpu_pkg::F_STA && !dest_st |=> mem.we && mem.addr == $past(phys);
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("bad addr");
  property p_store_keep;
    @(posedge hclk) disable iff (!hresetn)
    go && op == word_cpu_pkg::F_STA && !w_acc |=> acc == $past(acc);
  endproperty
  a_store_keep: assert property (p_store_keep) else $error("src changed");
  property p_add_negzero;
    @(posedge hclk) disable iff (!hresetn)
    go && op == word_cpu_pkg::F_ADD && ir.part == 3'd3 && opnd == '1 &&
      acc != 30'h0 && !w_acc |=> acc == $past(acc);
  endproperty
  a_add_negzero: assert property (p_add_negzero) else $error("carry lost");
  property p_rot30;
    @(posedge hclk) disable iff (!hresetn)
    go && op == word_cpu_pkg::F_SLR && cnt == 6'd30 && !w_acc |=> acc == $past(acc);
  endproperty
  a_rot30: assert property (p_rot30) else $error("rotate wrong");
  property p_signfill;
    @(posedge hclk) disable iff (!hresetn)
    go && op == word_cpu_pkg::F_SRS && cnt >= 6'd30 && !w_acc |=>
      acc == {30{$past(acc[29])}};
  endproperty
  a_signfill: assert property (p_signfill) else $error("fill wrong");
  property p_ssub;
    @(posedge hclk) disable iff (!hresetn)
    go && op == word_cpu_pkg::F_SSU && qr == 30'h0 && !dest_st && !w_acc |=>
      acc == $past(acc);
  endproperty
  a_ssub: assert property (p_ssub) else $error("substitute wrong");
  // First run of an instruction with three executions left.
  sequence s_rpt3;
    go && !is_rpt && RPT_W >= 2 && rpt_left == RPT_W'(3);
  endsequence
  property p_repeat;
    @(posedge hclk) disable iff (!hresetn)
    s_rpt3 |=> go ##1 go ##1 !go;
  endproperty
  a_repeat: assert property (p_repeat) else $error("repeat count");
  property p_jump;
    @(posedge hclk) disable iff (!hresetn)
    go && op == word_cpu_pkg::F_JMP && ir.mod == 3'd0 |=>
      pc == $past(eff) && ret == $past(pc) + 17'd1;
  endproperty
  a_jump: assert property (p_jump) else $error("jump wrong");
endmodule : word_cpu_decode_execute
`default_nettype wire

// >>> test/core_store.sv
// Behavioural primary storage that records each word the block writes.
// Assumes mem.addr and mem.data are valid in the cycle that mem.we is high.
`default_nettype none
module core_store (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire word_cpu_pkg::mem_req_t mem,
  output logic [16:0]                 last_addr,
  output logic [29:0]                 last_data
);
  timeunit 1ns;
  timeprecision 1ns;
  // Capture the location and word of every write pulse.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_addr <= 17'h0;
      last_data <= 30'h0;
    end else if (mem.we) begin
      last_addr <= mem.addr;
      last_data <= mem.data;
    end
  end
endmodule : core_store
`default_nettype wire

// >>> test/tb_word_cpu_decode_execute.sv
// Self-checking bench that runs instructions through the register bus.
// Assumes a zero-wait slave whose hreadyout feeds the bus hready.
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_word_cpu_decode_execute;
  timeunit 1ns;
  timeprecision 1ns;
  logic                   hclk = 1'b0;      // Bus clock.
  logic                   hresetn = 1'b0;   // Active-low reset.
  logic                   hsel = 1'b0;      // Slave select.
  logic [31:0]            haddr = 32'h0;    // Byte address.
  logic [1:0]             htrans = 2'h0;    // Transfer kind.
  logic                   hwrite = 1'b0;    // Write when high.
  logic [31:0]            hwdata = 32'h0;   // Write data.
  logic                   hreadyout;        // Slave ready.
  logic                   hresp;            // Slave response.
  logic [31:0]            hrdata;           // Read data.
  word_cpu_pkg::mem_req_t mem;              // Storage write request.
  word_cpu_pkg::io_req_t  io;               // Channel start request.
  logic [16:0]            last_addr;        // Last stored location.
  logic [29:0]            last_data;        // Last stored word.
  int                     bad_count = 0;    // Mismatches seen.
  int                     num_checks = 0;   // Comparisons made.
  logic [29:0]            opnd [5] = '{30'h00f00f00, 30'h0ffffff0, 30'h0f0000f0,
                                       30'h0f0ff0f0, 30'h0ff0ff00};  // Logic results.
  logic [5:0]             lop [5] = '{word_cpu_pkg::F_AND, word_cpu_pkg::F_SST,
                                      word_cpu_pkg::F_SCL, word_cpu_pkg::F_SCP,
                                      word_cpu_pkg::F_SSU};  // Logic functions.
  // The clock toggles every half period of 20 ns.
  always #20 hclk = ~hclk;
  word_cpu_decode_execute dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mem(mem), .io(io));
  core_store store (.hclk(hclk), .hresetn(hresetn), .mem(mem), .last_addr(last_addr),
    .last_data(last_data));
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict;
    $display("Checks %0d, errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // Compares two values and reports a mismatch.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Waits for an edge with ready high, under a bound.
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        bad_count++;
        give_verdict();
      end
      @(posedge hclk);
    end
  endtask : wait_rdy
  // One single AHB-Lite transfer: address phase, then data phase.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : bus
  // Register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  // Register read compared against an expected value.
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    `CHK(x, e);
  endtask : rdchk
  // Executes one normal instruction and lets its results settle.
  task automatic run(input logic [5:0] f, input logic [2:0] m, input logic [2:0] p,
                     input logic [2:0] b, input logic [14:0] y);
    wr(word_cpu_pkg::OFF_INSTR, {2'h0, f, m, p, b, y});
    repeat (3) @(posedge hclk);
  endtask : run
  // Reset values and an unmapped offset.
  task automatic t_reset;
    rdchk(word_cpu_pkg::OFF_ACC, 32'h0);
    wr(8'h3c, 32'h1234);
    rdchk(8'h3c, 32'h0);
  endtask : t_reset
  // Indexed and plain immediate operands.
  task automatic t_index;
    wr(word_cpu_pkg::OFF_IDX + 8'h04, 32'h5);
    run(word_cpu_pkg::F_LDA, 3'h0, 3'h0, 3'h1, 15'h3);
    rdchk(word_cpu_pkg::OFF_ACC, 32'h8);
    run(word_cpu_pkg::F_LDA, 3'h0, 3'h0, 3'h0, 15'h3);
    rdchk(word_cpu_pkg::OFF_ACC, 32'h3);
  endtask : t_index
  // A carry out of the sign position comes back in at the bottom.
  task automatic t_add;
    wr(word_cpu_pkg::OFF_ACC, 32'h3ffffffe);
    run(word_cpu_pkg::F_ADD, 3'h0, 3'h0, 3'h0, 15'h2);
    rdchk(word_cpu_pkg::OFF_ACC, 32'h1);
    wr(word_cpu_pkg::OFF_OPND, 32'h3fffffff);
    run(word_cpu_pkg::F_ADD, 3'h0, 3'h3, 3'h0, 15'h0);
    rdchk(word_cpu_pkg::OFF_ACC, 32'h1);
  endtask : t_add
  // Every masking function on one accumulator and operand pair.
  task automatic t_logic;
    wr(word_cpu_pkg::OFF_QREG, 32'h0000ffff);
    wr(word_cpu_pkg::OFF_OPND, 32'h00ffff00);
    for (int i = 0; i < 5; i++) begin
      wr(word_cpu_pkg::OFF_ACC, 32'h0ff00ff0);
      run(lop[i], 3'h0, 3'h3, 3'h0, 15'h0);
      rdchk(word_cpu_pkg::OFF_ACC, {2'h0, opnd[i]});
    end
  endtask : t_logic
  // Rotate left, zero-fill and sign-fill right by one, then by 30 and 63.
  task automatic t_shift;
    logic [5:0]  f [5] = '{word_cpu_pkg::F_SLR, word_cpu_pkg::F_SRZ, word_cpu_pkg::F_SRS,
                           word_cpu_pkg::F_SLR, word_cpu_pkg::F_SRS};
    logic [14:0] y [5] = '{15'h41, 15'h41, 15'h41, 15'h1e, 15'h3f};
    logic [31:0] e [5] = '{32'h3, 32'h10000000, 32'h30000000, 32'h20000001, 32'h3fffffff};
    for (int i = 0; i < 5; i++) begin
      wr(word_cpu_pkg::OFF_ACC, 32'h20000001);
      run(f[i], 3'h0, 3'h0, 3'h0, y[i]);
      rdchk(word_cpu_pkg::OFF_ACC, e[i]);
    end
  endtask : t_shift
  // Store to a relocated location; the accumulator stays intact.
  task automatic t_store;
    wr(word_cpu_pkg::OFF_RELOC, 32'h100);
    wr(word_cpu_pkg::OFF_ACC, 32'h1234567);
    run(word_cpu_pkg::F_STA, 3'h0, 3'h3, 3'h0, 15'h20);
    `CHK(last_addr, 17'h120);
    `CHK(last_data, 30'h1234567);
    rdchk(word_cpu_pkg::OFF_ACC, 32'h1234567);
  endtask : t_store
  // Channel start fields; a load written straight behind it still runs.
  task automatic t_io;
    wr(word_cpu_pkg::OFF_INSTR, {2'h0, word_cpu_pkg::F_IO, 3'h5, 3'h6, 3'h0, 15'h0});
    wr(word_cpu_pkg::OFF_INSTR, {2'h0, word_cpu_pkg::F_LDA, 3'h0, 3'h0, 3'h0, 15'h7});
    `CHK(io.start, 1'b1);
    `CHK(io.chan, 4'hb);
    `CHK(io.mode, 2'h2);
    repeat (2) @(posedge hclk);
    rdchk(word_cpu_pkg::OFF_ACC, 32'h7);
  endtask : t_io
  // A repeat count of three runs the next add three times.
  task automatic t_repeat;
    wr(word_cpu_pkg::OFF_ACC, 32'h0);
    run(word_cpu_pkg::F_RPT, 3'h0, 3'h0, 3'h0, 15'h3);
    run(word_cpu_pkg::F_ADD, 3'h0, 3'h0, 3'h0, 15'h1);
    rdchk(word_cpu_pkg::OFF_ACC, 32'h3);
  endtask : t_repeat
  // Two jumps save the return location; a true compare skips one word.
  task automatic t_jump;
    run(word_cpu_pkg::F_JMP, 3'h0, 3'h0, 3'h0, 15'h100);
    run(word_cpu_pkg::F_JMP, 3'h0, 3'h0, 3'h0, 15'h200);
    rdchk(word_cpu_pkg::OFF_PC, 32'h200);
    rdchk(word_cpu_pkg::OFF_RET, 32'h101);
    wr(word_cpu_pkg::OFF_ACC, 32'h3);
    run(word_cpu_pkg::F_CMA, 3'h1, 3'h0, 3'h0, 15'h2);
    rdchk(word_cpu_pkg::OFF_PC, 32'h202);
  endtask : t_jump
  // Main sequence.
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_index();
    t_add();
    t_logic();
    t_shift();
    t_store();
    t_io();
    t_repeat();
    t_jump();
    give_verdict();
  end
endmodule : tb_word_cpu_decode_execute
`default_nettype wire
